// [hw/rtt_params.svh]
// Offsets, field positions, reset values and timing counts of the
// 16-bit real-time-capable timer. Included by the timer's design file.
`ifndef RTT_PARAMS_SVH
`define RTT_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave
`define RTT_CTRL_OFS      8'h00
`define RTT_COUNT_OFS     8'h04
`define RTT_CFG_OFS       8'h08

// Control register field positions
`define RTT_ON_BIT        15
`define RTT_IDLE_BIT      13
`define RTT_GATE_BIT      6
`define RTT_PS_HI         5
`define RTT_PS_LO         4
`define RTT_SYNC_BIT      2
`define RTT_SRC_BIT       1
// Writable bits of the control register, the rest read as zero
`define RTT_CTRL_MASK     16'hA076
// Configuration register: bit 0 routes the 32 kHz oscillator
`define RTT_CFG_LPOSC_BIT 0

// Reset values
`define RTT_CTRL_RST      16'h0000
`define RTT_COUNT_RST     16'h0000
`define RTT_CFG_RST       1'b0

// Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define RTT_PS_LIM_1      8'h00
`define RTT_PS_LIM_8      8'h07
`define RTT_PS_LIM_64     8'h3F
`define RTT_PS_LIM_256    8'hFF

// AXI answers
`define RTT_RESP_OKAY     2'b00
`define RTT_RESP_SLVERR   2'b10

`endif

// [hw/rtt_pkg.sv]
// Types shared by the 16-bit real-time-capable timer.
// Assumes nothing of its surroundings.
package rtt_pkg;

   // Prescale codes
   typedef enum logic [1:0] {
      RTT_PS_1, RTT_PS_8, RTT_PS_64, RTT_PS_256
   } rtt_ps_t;

   // Operating modes decoded from the control register
   typedef enum logic [1:0] {
      RTT_MODE_TIMER, RTT_MODE_GATED, RTT_MODE_SYNC, RTT_MODE_ASYNC
   } rtt_mode_t;

   // Control register fields, held packed
   typedef struct packed {
      logic    counter_on;
      logic    halt_in_idle;
      logic    gated_accumulate_enable;
      rtt_ps_t prescale_select;
      logic    external_sync_select;
      logic    count_source_select;
   } rtt_ctrl_t;

endpackage : rtt_pkg

// [hw/rtt_timer.sv]
// 16-bit timer/counter usable as a real-time-clock time base, with an
// AXI4-Lite register slave. Assumes a single 100 MHz clock, and that the
// pins and the 32 kHz oscillator level arrive synchronous to it.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rtt_params.svh"

module rtt_timer #(
   parameter int FCY_DIV = 1           // Instruction clock divider
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Timer pins
   input  wire logic        external_count_clock_pin,
   input  wire logic        lp_osc_32k,
   input  wire logic        gate_in,
   input  wire logic        idle_mode,
   output var  logic [15:0] count_value,
   output var  logic        wrap_pulse
);

   rtt_pkg::rtt_ctrl_t ctrl_r;         // Control register
   logic [15:0]        cnt_r;          // The counter itself
   logic               lposc_sel_r;    // 32 kHz oscillator routing
   logic [7:0]         awaddr_r;       // Held write address
   logic               aw_held_r;      // Write address taken
   logic [31:0]        wdata_r;        // Held write data
   logic [3:0]         wstrb_r;        // Held write strobes
   logic               w_held_r;       // Write data taken
   logic [7:0]         fcy_cnt_r;      // Instruction clock divider
   logic               fcy_tick;       // Instruction clock enable
   logic               ext_q_r;        // Last external level
   logic               ext_src;        // Selected external level
   logic               ext_edge;       // External rising edge
   logic               run_w;          // Counter allowed to run
   logic               ps_in;          // Prescaler input pulse
   logic [7:0]         ps_cnt_r;       // Prescaler count
   logic [7:0]         ps_lim;         // Prescaler terminal count
   logic               ps_tick;        // Prescaler output pulse
   logic               sync1_r;        // Sync stage one
   logic               sync2_r;        // Sync stage two
   logic               cnt_tick;       // Counter increment pulse
   logic               wr_fire;        // Register write this cycle
   logic               cnt_wr;         // Counter written this cycle
   rtt_pkg::rtt_mode_t mode;           // Decoded mode
   logic [15:0]        ctrl_word;      // Control register as read
   // Control register packed into its bit positions
   always_comb begin
      ctrl_word = 16'h0000;
      ctrl_word[`RTT_ON_BIT]   = ctrl_r.counter_on;
      ctrl_word[`RTT_IDLE_BIT] = ctrl_r.halt_in_idle;
      ctrl_word[`RTT_GATE_BIT] = ctrl_r.gated_accumulate_enable;
      ctrl_word[`RTT_PS_HI:`RTT_PS_LO] = ctrl_r.prescale_select;
      ctrl_word[`RTT_SYNC_BIT] = ctrl_r.external_sync_select;
      ctrl_word[`RTT_SRC_BIT]  = ctrl_r.count_source_select;
   end
   // Mode decode; unused bits of each mode are ignored
   always_comb begin
      if (!ctrl_r.count_source_select) begin
         mode = ctrl_r.gated_accumulate_enable ?
                rtt_pkg::RTT_MODE_GATED : rtt_pkg::RTT_MODE_TIMER;
      end else begin
         mode = ctrl_r.external_sync_select ?
                rtt_pkg::RTT_MODE_SYNC : rtt_pkg::RTT_MODE_ASYNC;
      end
   end
   // Write channel: address and data taken in either order
   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
   assign cnt_wr  = wr_fire && (awaddr_r == `RTT_COUNT_OFS);
   // Write address holding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         awaddr_r  <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end
   end
   // Write data holding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end
   end
   // Ready while nothing is held; one write at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
                          && !s_axi_bvalid;
         s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready)
                          && !s_axi_bvalid;
      end
   end
   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RTT_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         if (awaddr_r == `RTT_CTRL_OFS || awaddr_r == `RTT_COUNT_OFS ||
             awaddr_r == `RTT_CFG_OFS) begin
            s_axi_bresp <= `RTT_RESP_OKAY;
         end else begin
            s_axi_bresp <= `RTT_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   // Control register on byte lanes 0 and 1, configuration register on byte lane 0
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r      <= rtt_pkg::rtt_ctrl_t'(7'h00);
         lposc_sel_r <= `RTT_CFG_RST;
      end else if (wr_fire && awaddr_r == `RTT_CTRL_OFS) begin
         if (wstrb_r[1]) begin
            ctrl_r.counter_on   <= wdata_r[`RTT_ON_BIT];
            ctrl_r.halt_in_idle <= wdata_r[`RTT_IDLE_BIT];
         end
         if (wstrb_r[0]) begin
            ctrl_r.gated_accumulate_enable <= wdata_r[`RTT_GATE_BIT];
            ctrl_r.prescale_select <=
               rtt_pkg::rtt_ps_t'(wdata_r[`RTT_PS_HI:`RTT_PS_LO]);
            ctrl_r.external_sync_select <= wdata_r[`RTT_SYNC_BIT];
            ctrl_r.count_source_select  <= wdata_r[`RTT_SRC_BIT];
         end
      end else if (wr_fire && awaddr_r == `RTT_CFG_OFS && wstrb_r[0]) begin
         lposc_sel_r <= wdata_r[`RTT_CFG_LPOSC_BIT];
      end
   end
   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RTT_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `RTT_RESP_OKAY;
         case (s_axi_araddr)
            `RTT_CTRL_OFS:  s_axi_rdata <= {16'h0000, ctrl_word};
            `RTT_COUNT_OFS: s_axi_rdata <= {16'h0000, cnt_r};
            `RTT_CFG_OFS:   s_axi_rdata <= {31'h0000_0000, lposc_sel_r};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `RTT_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end
   // Instruction clock enable from the system clock
   always_ff @(posedge aclk) begin
      if (!aresetn || fcy_cnt_r == 8'(FCY_DIV - 1)) begin
         fcy_cnt_r <= 8'h00;
      end else begin
         fcy_cnt_r <= fcy_cnt_r + 8'h01;
      end
   end
   assign fcy_tick = (fcy_cnt_r == 8'(FCY_DIV - 1));
   // External level: pin or 32 kHz oscillator, rising edge detect
   assign ext_src = lposc_sel_r ? lp_osc_32k
                                : external_count_clock_pin;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_q_r <= 1'b0;
      end else begin
         ext_q_r <= ext_src;
      end
   end
   assign ext_edge = ext_src && !ext_q_r;
   // Running: on, and not halted by idle
   assign run_w = ctrl_r.counter_on &&
                  !(ctrl_r.halt_in_idle && idle_mode);
   // Prescaler input by source; gate only in gated timer mode
   always_comb begin
      if (!run_w) begin
         ps_in = 1'b0;
      end else if (ctrl_r.count_source_select) begin
         ps_in = ext_edge;
      end else if (ctrl_r.gated_accumulate_enable) begin
         ps_in = fcy_tick && gate_in;
      end else begin
         ps_in = fcy_tick;
      end
   end
   // Prescaler terminal count
   always_comb begin
      case (ctrl_r.prescale_select)
         rtt_pkg::RTT_PS_1:   ps_lim = `RTT_PS_LIM_1;
         rtt_pkg::RTT_PS_8:   ps_lim = `RTT_PS_LIM_8;
         rtt_pkg::RTT_PS_64:  ps_lim = `RTT_PS_LIM_64;
         rtt_pkg::RTT_PS_256: ps_lim = `RTT_PS_LIM_256;
         default:             ps_lim = `RTT_PS_LIM_1;
      endcase
   end
   assign ps_tick = ps_in && (ps_cnt_r >= ps_lim);
   // Prescaler count, cleared while counter_on is low, held while halted in idle
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_r.counter_on) begin
         ps_cnt_r <= 8'h00;
      end else if (ps_tick) begin
         ps_cnt_r <= 8'h00;
      end else if (ps_in) begin
         ps_cnt_r <= ps_cnt_r + 8'h01;
      end
   end
   // Sync stages on the prescaler output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= ps_tick;
         sync2_r <= sync1_r;
      end
   end
   // Sync mode uses the delayed pulse, others the direct one
   assign cnt_tick = run_w && ((mode == rtt_pkg::RTT_MODE_SYNC) ?
                     sync2_r : ps_tick);
   // The 16-bit counter; a software write wins over an increment
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= `RTT_COUNT_RST;
      end else if (cnt_wr) begin
         if (wstrb_r[0]) cnt_r[7:0]  <= wdata_r[7:0];
         if (wstrb_r[1]) cnt_r[15:8] <= wdata_r[15:8];
      end else if (cnt_tick) begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end
   // Registered outputs: count mirror and rollover pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_value <= `RTT_COUNT_RST;
         wrap_pulse  <= 1'b0;
      end else begin
         count_value <= cnt_r;
         wrap_pulse  <= cnt_tick && !cnt_wr && (cnt_r == 16'hFFFF);
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Eight-cycle prescaler period in 1:8 timer mode
   logic div8_ok;
   assign div8_ok = run_w && FCY_DIV == 1 && !wr_fire &&
                    mode == rtt_pkg::RTT_MODE_TIMER &&
                    ctrl_r.prescale_select == rtt_pkg::RTT_PS_8;
   sequence s_div8_gap;
      !ps_tick [*7] ##1 ps_tick;
   endsequence
   sequence s_sync_path;
      sync1_r ##1 sync2_r;
   endsequence

   a_count_incr: assert property (cnt_tick && !cnt_wr |=>
      cnt_r == $past(cnt_r) + 16'h0001) else $error("count not advanced");
   a_stop_holds: assert property (!ctrl_r.counter_on && !cnt_wr |=>
      $stable(cnt_r)) else $error("count moved while off");
   a_idle_halt: assert property (ctrl_r.halt_in_idle && idle_mode
      |-> !cnt_tick && !ps_in) else $error("count moved in idle");
   a_gate_low: assert property (mode == rtt_pkg::RTT_MODE_GATED &&
      !gate_in |-> !ps_in) else $error("gated count with gate low");
   a_src_internal: assert property (run_w && !ctrl_r.count_source_select
      && !ctrl_r.gated_accumulate_enable |-> ps_in == fcy_tick)
      else $error("timer mode ignores instruction clock");
   a_src_external: assert property (run_w &&
      ctrl_r.count_source_select |-> ps_in == ext_edge)
      else $error("counter mode ignores pin edge");
   a_div8_period: assert property (disable iff (!aresetn || !div8_ok)
      ps_tick |=> s_div8_gap) else $error("1:8 period wrong");
   a_sync_delay: assert property (ps_tick &&
      mode == rtt_pkg::RTT_MODE_SYNC |=> s_sync_path ##0 (cnt_tick || !run_w))
      else $error("sync stage lost a pulse");
   a_async_direct: assert property (run_w &&
      mode == rtt_pkg::RTT_MODE_ASYNC |-> cnt_tick == ps_tick)
      else $error("async count delayed");
   a_mode_decode: assert property (ctrl_r.count_source_select &&
      !ctrl_r.external_sync_select |-> mode == rtt_pkg::RTT_MODE_ASYNC)
      else $error("mode decode wrong");

endmodule : rtt_timer
`default_nettype wire

// [verification/rtt_clk_src.sv]
// Behavioural far side of the timer: external count clock pin and 32 kHz
// oscillator. Assumes burst is called just after a rising edge of aclk.
`timescale 1ns/1ps
`default_nettype none
module rtt_clk_src (
   input  wire logic aclk,
   output var  logic pin,
   output var  logic osc
);
   // Both lines rest low outside bursts, like a stopped source
   initial begin
      pin = 1'b0;
      osc = 1'b0;
   end
   // Sends n rising edges, each level held h cycles, on one line only
   task automatic burst(input int n, input int h, input bit sel);
      int i;
      for (i = 0; i < 2 * n; i++) begin
         if (sel) osc <= ~osc;
         else pin <= ~pin;
         repeat (h) @(posedge aclk);
      end
   endtask : burst
endmodule : rtt_clk_src
`default_nettype wire

// [verification/rtt_timer_tb.sv]
// Self-checking bench of the timer: AXI4-Lite master tasks, one task
// per scenario. Assumes FCY_DIV of 1 and the source model beside it.
`timescale 1ns/1ps
`default_nettype none
module rtt_timer_tb;
   logic        aclk = 1'b0;        // 100 MHz clock
   logic        aresetn = 1'b0;     // Synchronous reset, active low
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awready, wready, bvalid, arready, rvalid, wrap;
   logic [1:0]  bresp, rresp;
   logic        pin, osc;
   logic        gate_in = 1'b0, idle_mode = 1'b0;
   logic [15:0] count_value;
   int          n_errors = 0, tests_run = 0;

   always #5 aclk = ~aclk;

   rtt_timer #(.FCY_DIV(1)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .external_count_clock_pin(pin),
      .lp_osc_32k(osc), .gate_in(gate_in), .idle_mode(idle_mode),
      .count_value(count_value), .wrap_pulse(wrap));

   rtt_clk_src SRC (.aclk(aclk), .pin(pin), .osc(osc));

   // Prints the counts and the verdict, then stops
   task automatic conclude();
      $display("errors %0d of %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   // Compares one value, counting the check and any mismatch
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Wait that ran out of its bound
   task automatic hang();
      n_errors++;
      $display("[ERR] %0t handshake timeout", $time);
      conclude();
   endtask : hang

   // One AXI write: address and data offered together, each held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      bit aw, w;
      int i;
      aw = 0;
      w = 0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      for (i = 0; !(aw && w); i++) begin
         @(posedge aclk);
         if (i > 50) hang();
         if (!aw && awready === 1'b1) begin
            aw = 1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1;
            wvalid <= 1'b0;
         end
      end
      // Response ready raised only once both halves are taken
      bready <= 1'b1;
      i = 0;
      do begin
         @(posedge aclk);
         i++;
         if (i > 50) hang();
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(bresp, er);
   endtask : wr

   // One AXI read, ready held up until the answer is sampled
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int i;
      araddr <= a;
      arvalid <= 1'b1;
      // Address offered at one edge at least before it can be taken
      i = 0;
      do begin
         @(posedge aclk);
         i++;
         if (i > 50) hang();
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      i = 0;
      do begin
         @(posedge aclk);
         i++;
         if (i > 50) hang();
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, ed);
      chk(rresp, er);
   endtask : rd

   // Restarts the counter from zero with a new control word
   task automatic setup(input logic [15:0] c, input logic cfg);
      wr(8'h00, 32'h0, 2'b00);
      wr(8'h04, 32'h0, 2'b00);
      wr(8'h08, {31'h0, cfg}, 2'b00);
      wr(8'h00, {16'h0, c}, 2'b00);
      repeat (8) @(posedge aclk);
   endtask : setup

   // Counts the increments seen on count_value over n cycles
   task automatic window(input int n, input logic [15:0] exp);
      logic [15:0] c0;
      c0 = count_value;
      repeat (n) @(posedge aclk);
      chk(16'(count_value - c0), exp);
   endtask : window

   // Reset values, writable bits and unmapped addresses
   task automatic t_regs();
      rd(8'h00, 32'h0, 2'b00);
      rd(8'h04, 32'h0, 2'b00);
      rd(8'h08, 32'h0, 2'b00);
      wr(8'h00, 32'h0000FFFF, 2'b00);
      rd(8'h00, 32'h0000A076, 2'b00);
      wr(8'h0C, 32'h0000FFFF, 2'b10);
      rd(8'h0C, 32'h0, 2'b10);
   endtask : t_regs

   // Instruction-clock timer through every prescale code, then stopped
   task automatic t_prescale();
      int k;
      int sh [4] = '{0, 3, 6, 8};
      for (k = 0; k < 4; k++) begin
         setup(16'h8000 | 16'(k << 4), 1'b0);
         window(1024, 16'(1024 >> sh[k]));
      end
      wr(8'h00, 32'h0, 2'b00);
      window(300, 16'h0000);
   endtask : t_prescale

   // Gate low holds the count, gate high lets every cycle through
   task automatic t_gated();
      setup(16'h8040, 1'b0);
      window(100, 16'h0000);
      @(posedge aclk);
      gate_in <= 1'b1;
      repeat (4) @(posedge aclk);
      window(100, 16'h0064);
      @(posedge aclk);
      gate_in <= 1'b0;
   endtask : t_gated

   // Idle halts the counter only when halt_in_idle is set
   task automatic t_idle();
      @(posedge aclk);
      idle_mode <= 1'b1;
      setup(16'hA000, 1'b0);
      window(100, 16'h0000);
      setup(16'h8000, 1'b0);
      window(100, 16'h0064);
      @(posedge aclk);
      idle_mode <= 1'b0;
   endtask : t_idle

   // External edges, async and sync, prescaled, and from the oscillator
   task automatic t_extern(input logic [15:0] c, input bit cfg,
                           input int n, input logic [31:0] exp);
      setup(c, cfg);
      SRC.burst(n, 3, cfg);
      repeat (8) @(posedge aclk);
      rd(8'h04, exp, 2'b00);
   endtask : t_extern

   // Counter rolls over from FFFF to 0000 with a wrap pulse
   task automatic t_wrap();
      int i;
      wr(8'h00, 32'h0, 2'b00);
      wr(8'h04, 32'h0000FFFE, 2'b00);
      wr(8'h00, 32'h00008000, 2'b00);
      for (i = 0; wrap !== 1'b1; i++) begin
         @(posedge aclk);
         if (i > 20) hang();
      end
      @(posedge aclk);
      chk(count_value, 32'h0000_0000);
      chk(wrap, 1'b0);
   endtask : t_wrap

   // Main sequence
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_prescale();
      t_gated();
      t_idle();
      t_extern(16'h8002, 1'b0, 20, 32'd20);
      t_extern(16'h8006, 1'b0, 20, 32'd20);
      t_extern(16'h8012, 1'b0, 64, 32'd8);
      t_extern(16'h8002, 1'b1, 20, 32'd20);
      t_wrap();
      conclude();
   end
endmodule : rtt_timer_tb
`default_nettype wire
